// ### pkg/psq_pkg.sv
package psq_pkg;
  // ------------------------------------------------------------
  // build and timing
  // ------------------------------------------------------------
  localparam int PHASES          = 4;
  localparam int PC_W_SMALL      = 11;
  localparam int PC_W_LARGE      = 12;
  localparam int WORD_W_SMALL    = 14;
  localparam int WORD_W_LARGE    = 15;
  localparam int STACK_LEVELS    = 6;

  // ------------------------------------------------------------
  // register offsets (data memory space)
  // ------------------------------------------------------------
  localparam logic [6:0] OFS_PC_LOW    = 7'h06;
  localparam logic [6:0] OFS_TBL_LOW   = 7'h07;
  localparam logic [6:0] OFS_TBL_HIGH  = 7'h08;
  localparam logic [7:0] TBL_LOW_RESET = 8'h00;
  localparam logic [7:0] TBL_HI_RESET  = 8'h00;

  // ------------------------------------------------------------
  // vectors
  // ------------------------------------------------------------
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT   = 12'h004;
  localparam logic [11:0] VEC_TMR   = 12'h008;
  localparam logic [11:0] VEC_ADC   = 12'h00c;

  // ------------------------------------------------------------
  // decoded control from the instruction decoder
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PSQ_OP_NEXT   = 3'h0,
    PSQ_OP_SKIP   = 3'h1,
    PSQ_OP_JUMP   = 3'h2,
    PSQ_OP_CALL   = 3'h3,
    PSQ_OP_RET    = 3'h4,
    PSQ_OP_RD_CUR = 3'h5,
    PSQ_OP_RD_LST = 3'h6
  } psq_op_e;

  typedef struct packed {
    psq_op_e     op;
    logic        skip_true;
    logic [11:0] target;
    logic [6:0]  table_dest;
  } psq_exec_s;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } psq_dwr_s;

  typedef enum logic [1:0] {
    PSQ_ST_RUN   = 2'b00,
    PSQ_ST_FLUSH = 2'b01,
    PSQ_ST_TABLE = 2'b11
  } psq_state_e;
endpackage

// ### rtl/psq_phase_gen.sv
`timescale 1ns/1ps
module psq_phase_gen (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // phase outputs
  output logic [3:0] phase,
  output logic       cycle_end
);
  import psq_pkg::*;

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [3:0] phase_reg;
  logic [3:0] phase_next;

  always_comb begin
    cnt_next   = cnt_reg + 2'h1;
    phase_next = 4'h1 << cnt_next;                     // [RULE1]
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= 2'h0;
      phase_reg <= 4'h1;
    end else begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
    end
  end

  assign phase     = phase_reg;
  assign cycle_end = phase_reg[PHASES-1];              // [RULE1]
endmodule // psq_phase_gen

// ### rtl/psq_sequencer.sv
`timescale 1ns/1ps
// Contract
// [RULE1] four clock phases per instruction cycle
// [RULE2] fetch overlaps previous instruction's execute
// [RULE3] pc-changing instructions take two cycles
// [RULE4] pc width 11 or 12 bits
// [RULE5] pc increments after each fetch
// [RULE6] true skip discards fetched instruction
// [RULE7] reset clears pc to zero
// [RULE8] external interrupt vectors to 004
// [RULE9] timer interrupt vectors to 008
// [RULE10] converter interrupt vectors to 00c
// [RULE11] pc low write jumps within page
// [RULE12] jump and call load full address
// [RULE13] return reloads pc from stack top
// [RULE14] current-page read uses pc upper bits
// [RULE15] last-page read forces upper bits one
// [RULE16] table read splits word low/high
// [RULE17] table pointer readable and writable
// [RULE18] table high is read-only
// [RULE19] table reads take two cycles
// [RULE20] memory addressed by pc or pointer
// [RULE21] stack full withholds interrupt acknowledge
// [RULE22] interrupt priority external, timer, converter
module psq_sequencer #(
  parameter int PC_W   = psq_pkg::PC_W_LARGE,
  parameter int WORD_W = psq_pkg::WORD_W_LARGE
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // program memory
  output logic [PC_W-1:0]          pm_addr,
  input  wire logic [WORD_W-1:0]   pm_data,
  // decoder side
  output logic [WORD_W-1:0]        instr,
  output logic                     instr_valid,
  output logic                     cycle_end,
  input  wire psq_pkg::psq_exec_s  exec,
  // data memory write and read of special registers
  input  wire psq_pkg::psq_dwr_s   dwr,
  input  wire logic [6:0]          rd_addr,
  output logic [7:0]               rd_data,
  output psq_pkg::psq_dwr_s        tbl_wr,
  // interrupts: enabled requests, acknowledge pulses
  input  wire logic [2:0]          irq_pend,
  output logic [2:0]               irq_ack,
  // status
  output logic [PC_W-1:0]          pc
);
  import psq_pkg::*;

  localparam int SP_W = 3;

  // ------------------------------------------------------------
  // phase generator
  // ------------------------------------------------------------
  logic       ic_end;

  psq_phase_gen u_phase (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .phase     (),
    .cycle_end (ic_end)
  );

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  psq_state_e            state_reg, state_next;
  logic [PC_W-1:0]       pc_reg, pc_next;                        // [RULE4]
  logic [WORD_W-1:0]     ir_reg, ir_next;
  logic                  irv_reg, irv_next;
  logic [7:0]            tlow_reg, tlow_next;
  logic [7:0]            thigh_reg, thigh_next;
  logic [PC_W-1:0]       addr_reg, addr_next;
  logic [PC_W-1:0]       stk_reg [STACK_LEVELS];
  logic [PC_W-1:0]       stk_next [STACK_LEVELS];
  logic [SP_W-1:0]       sp_reg, sp_next;
  logic [6:0]            tdest_reg, tdest_next;
  psq_dwr_s              twr_reg, twr_next;
  logic [2:0]            ack_reg, ack_next;
  logic [7:0]            rd_reg, rd_next;
  logic                  cend_reg;

  logic                  stack_full;
  logic                  push;
  logic [PC_W-1:0]       push_val;
  logic [PC_W-1:0]       stk_top;

  assign stack_full = (sp_reg == SP_W'(STACK_LEVELS));
  assign stk_top    = stk_reg[0];

  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    ir_next    = ir_reg;
    irv_next   = irv_reg;
    tlow_next  = tlow_reg;
    thigh_next = thigh_reg;
    addr_next  = addr_reg;
    sp_next    = sp_reg;
    tdest_next = tdest_reg;
    twr_next   = '0;
    ack_next   = '0;
    push       = 1'b0;
    push_val   = pc_reg;

    // software side, takes effect any phase
    if (dwr.wr && dwr.addr == OFS_TBL_LOW)
      tlow_next = dwr.data;                                       // [RULE17]
    // table high ignores writes                                  // [RULE18]

    if (ic_end) begin
      case (state_reg)
        PSQ_ST_RUN: begin
          // fetch word at pc is latched; execute of previous overlaps [RULE2]
          ir_next  = pm_data;
          irv_next = 1'b1;
          pc_next  = pc_reg + PC_W'(1);                           // [RULE5]
          addr_next = pc_next;
          if (irv_reg) begin
            case (exec.op)
              PSQ_OP_SKIP: if (exec.skip_true) begin
                irv_next   = 1'b0;                                // [RULE6]
                state_next = PSQ_ST_FLUSH;
              end
              PSQ_OP_JUMP, PSQ_OP_CALL: begin
                pc_next    = exec.target[PC_W-1:0];               // [RULE12]
                irv_next   = 1'b0;                                // [RULE3]
                state_next = PSQ_ST_FLUSH;
                if (exec.op == PSQ_OP_CALL) begin
                  push     = 1'b1;
                  push_val = pc_reg;
                end
              end
              PSQ_OP_RET: begin
                pc_next    = stk_top;                             // [RULE13]
                irv_next   = 1'b0;
                state_next = PSQ_ST_FLUSH;
              end
              PSQ_OP_RD_CUR: begin
                addr_next  = {pc_reg[PC_W-1:8], tlow_reg};        // [RULE14]
                tdest_next = exec.table_dest;
                irv_next   = 1'b0;
                state_next = PSQ_ST_TABLE;                        // [RULE19]
              end
              PSQ_OP_RD_LST: begin
                addr_next  = {{(PC_W-8){1'b1}}, tlow_reg};        // [RULE15]
                tdest_next = exec.table_dest;
                irv_next   = 1'b0;
                state_next = PSQ_ST_TABLE;
              end
              default: ;
            endcase
            if (dwr.wr && dwr.addr == OFS_PC_LOW) begin
              pc_next    = {pc_reg[PC_W-1:8], dwr.data};          // [RULE11]
              irv_next   = 1'b0;
              state_next = PSQ_ST_FLUSH;
            end
          end
          // interrupt entry replaces the next fetch
          if (state_next == PSQ_ST_RUN && irq_pend != 3'h0 && !stack_full) begin // [RULE21]
            // the fetch at pc_reg is dropped, so return resumes there
            push       = 1'b1;
            push_val   = pc_reg;
            irv_next   = 1'b0;
            state_next = PSQ_ST_FLUSH;
            if (irq_pend[0]) begin                                // [RULE22]
              pc_next  = VEC_EXT[PC_W-1:0];                       // [RULE8]
              ack_next = 3'b001;
            end else if (irq_pend[1]) begin
              pc_next  = VEC_TMR[PC_W-1:0];                       // [RULE9]
              ack_next = 3'b010;
            end else begin
              pc_next  = VEC_ADC[PC_W-1:0];                       // [RULE10]
              ack_next = 3'b100;
            end
          end
          if (state_next != PSQ_ST_TABLE)
            addr_next = pc_next;                                  // [RULE20]
        end
        PSQ_ST_TABLE: begin
          twr_next.wr   = 1'b1;                                   // [RULE16]
          twr_next.addr = tdest_reg;
          twr_next.data = pm_data[7:0];
          thigh_next    = 8'(pm_data[WORD_W-1:8]);
          // word fetched before the table read waited in ir
          irv_next      = 1'b1;                                   // [RULE19]
          addr_next     = pc_reg;
          state_next    = PSQ_ST_RUN;
        end
        PSQ_ST_FLUSH: begin
          // dummy cycle: refetch from new pc                     [RULE3]
          ir_next    = pm_data;
          irv_next   = 1'b1;
          pc_next    = pc_reg + PC_W'(1);                         // [RULE5]
          state_next = PSQ_ST_RUN;
          addr_next  = pc_next;
        end
        default: state_next = PSQ_ST_RUN;
      endcase
    end

    // stack: entry 0 is top; a call on a full stack drops the oldest
    for (int i = 0; i < STACK_LEVELS; i++)
      stk_next[i] = stk_reg[i];
    if (push) begin
      stk_next[0] = push_val;
      for (int i = 1; i < STACK_LEVELS; i++)
        stk_next[i] = stk_reg[i-1];
      if (!stack_full)
        sp_next = sp_reg + SP_W'(1);
    end else if (ic_end && state_reg == PSQ_ST_RUN && irv_reg &&
                 exec.op == PSQ_OP_RET) begin
      for (int i = 0; i < STACK_LEVELS - 1; i++)
        stk_next[i] = stk_reg[i+1];
      if (sp_reg != SP_W'(0))
        sp_next = sp_reg - SP_W'(1);                              // [RULE21]
    end

    case (rd_addr)
      OFS_PC_LOW:   rd_next = pc_reg[7:0];
      OFS_TBL_LOW:  rd_next = tlow_reg;                           // [RULE17]
      OFS_TBL_HIGH: rd_next = thigh_reg;
      default:      rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= PSQ_ST_RUN;
      pc_reg    <= VEC_RESET[PC_W-1:0];                           // [RULE7]
      ir_reg    <= '0;
      irv_reg   <= 1'b0;
      tlow_reg  <= TBL_LOW_RESET;
      thigh_reg <= TBL_HI_RESET;
      addr_reg  <= VEC_RESET[PC_W-1:0];
      sp_reg    <= '0;
      tdest_reg <= '0;
      twr_reg   <= '0;
      ack_reg   <= '0;
      rd_reg    <= 8'h00;
      cend_reg  <= 1'b0;
      for (int i = 0; i < STACK_LEVELS; i++)
        stk_reg[i] <= '0;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      ir_reg    <= ir_next;
      irv_reg   <= irv_next;
      tlow_reg  <= tlow_next;
      thigh_reg <= thigh_next;
      addr_reg  <= addr_next;
      sp_reg    <= sp_next;
      tdest_reg <= tdest_next;
      twr_reg   <= twr_next;
      ack_reg   <= ack_next;
      rd_reg    <= rd_next;
      cend_reg  <= ic_end;
      for (int i = 0; i < STACK_LEVELS; i++)
        stk_reg[i] <= stk_next[i];
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign pm_addr     = addr_reg;
  assign instr       = ir_reg;
  assign instr_valid = irv_reg;
  assign cycle_end   = cend_reg;
  assign rd_data     = rd_reg;
  assign tbl_wr      = twr_reg;
  assign irq_ack     = ack_reg;
  assign pc          = pc_reg;
endmodule // psq_sequencer

// ### verif/psq_chk.sv
`timescale 1ns/1ps
module psq_chk #(
  parameter int PC_W = psq_pkg::PC_W_LARGE
) (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               rst,
  // watched ports
  input wire logic [PC_W-1:0]    pc,
  input wire logic [PC_W-1:0]    pm_addr,
  input wire logic               instr_valid,
  input wire logic               cycle_end,
  input wire psq_pkg::psq_exec_s exec,
  input wire psq_pkg::psq_dwr_s  dwr,
  input wire psq_pkg::psq_dwr_s  tbl_wr,
  input wire logic [2:0]         irq_pend,
  input wire logic [2:0]         irq_ack
);
  import psq_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // exec is taken one sample after cycle_end
  // ----------------------------------------
  sequence s_go;
    cycle_end ##1 instr_valid;
  endsequence

  AST_CYCLE:
    assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("cycle_end spacing wrong");
  AST_RST:
    assert property ($fell(rst) |-> pc == '0 && !instr_valid)
    else $error("pc not zero after reset");
  AST_HOLD:
    assert property ($changed(pc) |-> ##[0:1] cycle_end)
    else $error("pc moved inside a cycle");
  AST_INC:
    assert property (s_go ##0 (exec.op == PSQ_OP_NEXT && !dwr.wr && irq_pend == 3'h0)
      |-> ##3 pc == $past(pc, 4) + 1'b1)
    else $error("pc did not step by one");
  AST_JMP:
    assert property (s_go ##0 (exec.op inside {PSQ_OP_JUMP, PSQ_OP_CALL})
      |-> ##3 pc == $past(exec.target, 3))
    else $error("pc not loaded with target");
  AST_DUMMY:
    assert property (s_go ##0 (exec.op inside {PSQ_OP_JUMP, PSQ_OP_CALL, PSQ_OP_RET,
      PSQ_OP_RD_CUR, PSQ_OP_RD_LST} || exec.op == PSQ_OP_SKIP && exec.skip_true)
      |-> ##3 !instr_valid ##4 instr_valid)
    else $error("dummy cycle missing");
  AST_LAST:
    assert property (s_go ##0 exec.op == PSQ_OP_RD_LST |-> ##3 &pm_addr[PC_W-1:8])
    else $error("last page read not on last page");
  AST_TWR:
    assert property (s_go ##0 exec.op inside {PSQ_OP_RD_CUR, PSQ_OP_RD_LST}
      |-> ##[1:12] tbl_wr.wr ##1 !tbl_wr.wr)
    else $error("table write pulse missing");
  AST_PRIO:
    assert property (|irq_ack |-> irq_ack == ($past(irq_pend) & (~$past(irq_pend) + 3'h1)))
    else $error("wrong interrupt serviced");
  AST_VEC:
    assert property (|irq_ack |-> pc == {8'h00, irq_ack[2] | irq_ack[1],
      irq_ack[2] | irq_ack[0], 2'b00})
    else $error("wrong interrupt vector");

  cover property (|irq_ack);
  cover property (tbl_wr.wr);
  cover property (s_go ##0 exec.op == PSQ_OP_RET);
endmodule // psq_chk

bind psq_sequencer psq_chk #(.PC_W(PC_W)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .pc(pc), .pm_addr(pm_addr), .instr_valid(instr_valid),
  .cycle_end(cycle_end), .exec(exec), .dwr(dwr), .tbl_wr(tbl_wr), .irq_pend(irq_pend),
  .irq_ack(irq_ack));

// ### verif/psq_pmem.sv
`timescale 1ns/1ps
module psq_pmem #(
  parameter bit SLOW = 1'b1
) (
  // clock
  input wire logic         ref_clk,
  // fetch port
  input wire logic  [11:0] pm_addr,
  output logic      [14:0] pm_data
);
  logic [11:0] addr_reg;
  logic [14:0] word;
  // every word is unique, so a wrong address never reads back right
  assign word = {pm_addr[11:5], pm_addr[7:0] ^ {pm_addr[11:8], pm_addr[11:8]}};
  // slow mode shows junk for a clock after each address change
  always @(posedge ref_clk) begin
    addr_reg <= pm_addr;
    pm_data  <= (SLOW && pm_addr != addr_reg) ? ~pm_data : word;
  end
endmodule // psq_pmem

// ### verif/tb_program_sequencer.sv
`timescale 1ns/1ps
module tb_program_sequencer;
  import psq_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] pm_addr, pc, a;
  logic [14:0] pm_data, instr;
  logic        instr_valid, cycle_end;
  psq_exec_s   exec = '0;
  psq_dwr_s    dwr = '0, tbl_wr, tw;
  logic [6:0]  rd_addr = 7'h00;
  logic [7:0]  rd_data, rdv;
  logic [2:0]  irq_pend = 3'h0, irq_ack, ack_seen = 3'h0;
  logic [11:0] vec [3] = '{VEC_EXT, VEC_TMR, VEC_ADC};
  int          error_cnt = 0, num_checks = 0, dd = 0;

  always #2 ref_clk = ~ref_clk;

  // 12-bit build
  psq_sequencer uut (.ref_clk(ref_clk), .rst(rst), .pm_addr(pm_addr), .pm_data(pm_data),
    .instr(instr), .instr_valid(instr_valid), .cycle_end(cycle_end), .exec(exec),
    .dwr(dwr), .rd_addr(rd_addr), .rd_data(rd_data), .tbl_wr(tbl_wr),
    .irq_pend(irq_pend), .irq_ack(irq_ack), .pc(pc));
  psq_pmem mem_model (.ref_clk(ref_clk), .pm_addr(pm_addr), .pm_data(pm_data));

  // pulses last one clock, so latch them for later compares
  always @(posedge ref_clk) begin
    if (!rst && tbl_wr.wr === 1'b1) tw = tbl_wr;
    if (!rst && irq_ack !== 3'h0) ack_seen = irq_ack;
  end

  function automatic logic [14:0] wd(input logic [11:0] x);
    return {x[11:5], x[7:0] ^ {x[11:8], x[11:8]}};
  endfunction

  function automatic psq_exec_s ex(input psq_op_e o, input logic [11:0] t = 12'h000,
                                   input logic [6:0] d = 7'h00, input logic s = 1'b0);
    return '{op: o, skip_true: s, target: t, table_dest: d};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ----------------------------------------
  // one instruction slot
  // ----------------------------------------
  // checks the slot at a, executes e; d dummies expected before nx
  task automatic go(input psq_exec_s e, input logic [11:0] nx, input int d,
                    input psq_dwr_s w = '0, input logic [2:0] irq = 3'h0,
                    input logic [6:0] ra = 7'h00);
    int n;
    n = 0;
    @(posedge ref_clk iff cycle_end === 1'b1);
    while (instr_valid !== 1'b1 && n < 4) begin
      exec <= ex(PSQ_OP_JUMP, 12'h7ff);
      dwr <= '0;
      irq_pend <= 3'h0;
      n++;
      @(posedge ref_clk iff cycle_end === 1'b1);
    end
    chk("dummy cycles", 16'(dd), 16'(n));
    chk("instr", {1'b0, wd(a)}, {1'b0, instr});
    chk("pc", {4'h0, a + 12'h001}, {4'h0, pc});
    exec <= e;
    dwr <= w;
    irq_pend <= irq;
    rd_addr <= ra;
    repeat (2) @(posedge ref_clk);
    rdv = rd_data;
    a = nx;
    dd = d;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    psq_exec_s nop;
    logic [11:0] r;
    logic [14:0] w;
    nop = ex(PSQ_OP_NEXT);
    a = 12'h000;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    go(nop, 12'h001, 0);
    go(nop, 12'h002, 0);
    go(ex(PSQ_OP_JUMP, 12'h123), 12'h123, 1);
    go(ex(PSQ_OP_SKIP, 12'h000, 7'h00, 1'b1), 12'h125, 1);
    go(ex(PSQ_OP_SKIP), 12'h126, 0);
    go(nop, 12'h140, 1, '{1'b1, OFS_PC_LOW, 8'h40});
    go(nop, 12'h141, 0, '{1'b1, OFS_TBL_LOW, 8'h37});
    go(ex(PSQ_OP_RD_CUR, 12'h000, 7'h2a), 12'h142, 1, '0, 3'h0, OFS_TBL_LOW);
    chk("table pointer", 16'h0037, {8'h00, rdv});
    go(ex(PSQ_OP_RD_LST, 12'h000, 7'h31), 12'h143, 1, '0, 3'h0, OFS_TBL_HIGH);
    w = wd(12'h137);
    chk("table write", {1'b1, 7'h2a, w[7:0]}, {tw.wr, tw.addr, tw.data});
    chk("table high", {9'h000, w[14:8]}, {8'h00, rdv});
    go(nop, 12'h144, 0, '{1'b1, OFS_TBL_HIGH, 8'hff}, 3'h0, OFS_TBL_HIGH);
    w = wd(12'hf37);
    chk("last page write", {1'b1, 7'h31, w[7:0]}, {tw.wr, tw.addr, tw.data});
    go(ex(PSQ_OP_CALL, 12'h200), 12'h200, 1, '0, 3'h0, OFS_TBL_HIGH);
    chk("table high kept", {9'h000, w[14:8]}, {8'h00, rdv});
    go(ex(PSQ_OP_RET), 12'h145, 1, '0, 3'h0, 7'h7f);
    chk("unmapped read", 16'h0000, {8'h00, rdv});
    // all three pending at once, then the rest after each return
    for (int k = 0; k < 3; k++) begin
      r = a + 12'h001;
      ack_seen = 3'h0;
      go(nop, vec[k], 1, '0, 3'b111 << k);
      go(ex(PSQ_OP_RET), r, 1);
      chk("ack", {13'h0000, 3'b001 << k}, {13'h0000, ack_seen});
    end
    for (int i = 0; i < STACK_LEVELS; i++) begin
      go(ex(PSQ_OP_CALL, 12'h300 + 12'(16 * i)), 12'h300 + 12'(16 * i), 1);
    end
    ack_seen = 3'h0;
    go(nop, 12'h351, 0, '0, 3'b001);
    go(ex(PSQ_OP_RET), 12'h341, 1);
    chk("ack withheld", 16'h0000, {13'h0000, ack_seen});
    go(nop, VEC_EXT, 1, '0, 3'b001);
    go(nop, VEC_EXT + 12'h001, 0);
    chk("ack after return", 16'h0001, {13'h0000, ack_seen});
    stop_test();
  end

  // 28 slots of at most 20 clocks each, with wide margin
  initial begin
    #20000;
    error_cnt++;
    $display("watchdog expired");
    stop_test();
  end
endmodule // tb_program_sequencer
